// file: rtl/sysbus_cfg.svh
`ifndef SYSBUS_CFG_SVH
`define SYSBUS_CFG_SVH
`define SB_DATA_W 64
`define SB_LANES 8
`define SB_LANE_W 8
`define SB_BEAT_W 3
`define SB_LAST_BEAT 3'h7
`define SB_FIRST_BEAT 3'h0
`define SB_TMO_W 8
`define SB_TMR_ZERO 8'h00
`define SB_TMR_ONE 8'h01
`define SB_DATA_ONE 64'h0000000000000001
`endif

// file: rtl/sysbus_pkg.sv
package sysbus_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_MST = 3'b010,
    D_GNT = 3'b100
  } dev_state_t;
  typedef enum logic [2:0] {
    F_IDLE = 3'b001,
    F_REQ = 3'b010,
    F_MST = 3'b100
  } far_state_t;
endpackage : sysbus_pkg

// file: rtl/sysbus_if.sv
`timescale 1ns/1ns
`include "sysbus_cfg.svh"
interface sysbus_if (
  input wire logic clk,
  input wire logic rst
);
  logic [`SB_DATA_W-1:0] dev_data_o;
  logic [`SB_DATA_W-1:0] far_data_o;
  logic [`SB_DATA_W-1:0] data;
  logic [`SB_LANES-1:0] dev_par_o;
  logic [`SB_LANES-1:0] far_par_o;
  logic [`SB_LANES-1:0] parity;
  logic dev_valid_o;
  logic far_valid_o;
  logic valid;
  logic dev_burst_o;
  logic far_burst_o;
  logic burst;
  logic dev_drv_oe_n;
  logic far_drv_oe_n;
  logic dev_ta_o;
  logic dev_ta_oe_n;
  logic far_ta_o;
  logic far_ta_oe_n;
  logic transfer_ack;
  logic dev_tea_o;
  logic dev_tea_oe_n;
  logic far_tea_o;
  logic far_tea_oe_n;
  logic transfer_error_ack;
  logic far_master_request_b;
  logic far_master_grant_c;
  logic far_master_data_grant_b;
  // data group: whichever end has its enable low owns data, parity, valid and burst
  assign data = !dev_drv_oe_n ? dev_data_o : (!far_drv_oe_n ? far_data_o : '0);
  assign parity = !dev_drv_oe_n ? dev_par_o : (!far_drv_oe_n ? far_par_o : '0);
  assign valid = (!dev_drv_oe_n && dev_valid_o) || (!far_drv_oe_n && far_valid_o);
  assign burst = (!dev_drv_oe_n && dev_burst_o) || (!far_drv_oe_n && far_burst_o);
  assign transfer_ack = (!dev_ta_oe_n && dev_ta_o) || (!far_ta_oe_n && far_ta_o);
  assign transfer_error_ack = (!dev_tea_oe_n && dev_tea_o) || (!far_tea_oe_n && far_tea_o);
  modport dev (
    input data, parity, valid, burst, transfer_ack, transfer_error_ack,
    input far_master_request_b,
    output dev_data_o, dev_par_o, dev_valid_o, dev_burst_o, dev_drv_oe_n,
    output dev_ta_o, dev_ta_oe_n, dev_tea_o, dev_tea_oe_n,
    output far_master_grant_c, far_master_data_grant_b
  );
  modport far (
    input data, parity, valid, burst, transfer_ack, transfer_error_ack,
    input far_master_grant_c, far_master_data_grant_b,
    output far_data_o, far_par_o, far_valid_o, far_burst_o, far_drv_oe_n,
    output far_ta_o, far_ta_oe_n, far_tea_o, far_tea_oe_n,
    output far_master_request_b
  );
endinterface : sysbus_if

// file: rtl/far_end.sv
`timescale 1ns/1ns
`include "sysbus_cfg.svh"
module far_end
  import sysbus_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sysbus_if.far bus,
  input wire logic own_req,
  input wire logic own_burst,
  input wire logic [`SB_DATA_W-1:0] own_wdata,
  output logic own_done,
  output logic own_err,
  output logic rx_valid,
  output logic [`SB_DATA_W-1:0] rx_data,
  output logic rx_par_err
);
  far_state_t state_r, state_nxt;
  logic [`SB_DATA_W-1:0] data_r, data_nxt, rx_data_r, rx_data_nxt;
  logic [`SB_LANES-1:0] par_r, par_nxt, par_exp;
  logic [`SB_BEAT_W-1:0] beat_r, beat_nxt;
  logic req_r, req_nxt, oe_n_r, oe_n_nxt, valid_r, valid_nxt, burst_r, burst_nxt;
  logic ta_r, ta_nxt, done_r, done_nxt, err_r, err_nxt;
  logic rx_valid_r, rx_valid_nxt, rx_perr_r, rx_perr_nxt;

  genvar i;
  generate
    for (i = 0; i < `SB_LANES; i++)
    begin : g_par
      assign par_nxt[i] = ~^data_nxt[i*`SB_LANE_W +: `SB_LANE_W];
      assign par_exp[i] = ~^bus.data[i*`SB_LANE_W +: `SB_LANE_W];
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;
    data_nxt = data_r;
    beat_nxt = beat_r;
    req_nxt = req_r;
    oe_n_nxt = oe_n_r;
    valid_nxt = valid_r;
    burst_nxt = burst_r;
    ta_nxt = 1'b0;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    rx_valid_nxt = 1'b0;
    rx_data_nxt = rx_data_r;
    rx_perr_nxt = 1'b0;
    // acting as target for beats the device drives; one ack per beat
    if (oe_n_r && bus.valid && !ta_r && !bus.transfer_error_ack)
    begin
      ta_nxt = 1'b1;
      rx_valid_nxt = 1'b1;
      rx_data_nxt = bus.data;
      rx_perr_nxt = (bus.parity != par_exp);
    end
    unique case (state_r)
      F_IDLE:
      begin
        if (own_req)
        begin
          state_nxt = F_REQ;
          req_nxt = 1'b1;
          data_nxt = own_wdata;
          burst_nxt = own_burst;
        end
      end
      F_REQ:
      begin
        if (bus.far_master_data_grant_b && bus.far_master_grant_c)
        begin
          state_nxt = F_MST;
          oe_n_nxt = 1'b0;
          valid_nxt = 1'b1;
          beat_nxt = `SB_FIRST_BEAT;
        end
      end
      F_MST:
      begin
        if (bus.transfer_error_ack)
        begin
          err_nxt = 1'b1;
          state_nxt = F_IDLE;
          req_nxt = 1'b0;
          oe_n_nxt = 1'b1;
          valid_nxt = 1'b0;
        end
        else if (bus.transfer_ack)
        begin
          if (!burst_r || beat_r == `SB_LAST_BEAT)
          begin
            done_nxt = 1'b1;
            state_nxt = F_IDLE;
            req_nxt = 1'b0;
            oe_n_nxt = 1'b1;
            valid_nxt = 1'b0;
          end
          else
          begin
            beat_nxt = beat_r + 1'b1;
            data_nxt = data_r + `SB_DATA_ONE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= F_IDLE;
      data_r <= '0;
      par_r <= '1;
      beat_r <= `SB_FIRST_BEAT;
      req_r <= 1'b0;
      oe_n_r <= 1'b1;
      valid_r <= 1'b0;
      burst_r <= 1'b0;
      ta_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r <= '0;
      rx_perr_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      data_r <= data_nxt;
      par_r <= par_nxt;
      beat_r <= beat_nxt;
      req_r <= req_nxt;
      oe_n_r <= oe_n_nxt;
      valid_r <= valid_nxt;
      burst_r <= burst_nxt;
      ta_r <= ta_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_data_r <= rx_data_nxt;
      rx_perr_r <= rx_perr_nxt;
    end
  end

  assign bus.far_data_o = data_r;
  assign bus.far_par_o = par_r;
  assign bus.far_valid_o = valid_r;
  assign bus.far_burst_o = burst_r;
  assign bus.far_drv_oe_n = oe_n_r;
  assign bus.far_ta_o = ta_r;
  assign bus.far_ta_oe_n = !ta_r;
  // this end never raises an error itself; only the device's monitor does
  assign bus.far_tea_o = 1'b0;
  assign bus.far_tea_oe_n = 1'b1;
  assign bus.far_master_request_b = req_r;
  assign own_done = done_r;
  assign own_err = err_r;
  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;
  assign rx_par_err = rx_perr_r;
endmodule : far_end

// file: rtl/dev_end.sv
`timescale 1ns/1ns
`include "sysbus_cfg.svh"
// Function
// - arbiter raises grant to far master
// - data driver also drives all parity lanes
// - lanes 6,7 odd parity over top bytes
// - lanes 0-5 odd parity per byte
// - responder acks each valid data beat
// - single beat ends on one ack
// - burst ends on eighth ack
// - error ack fails the data tenure
// - internal master watches error ack line
// - bus monitor raises error on stuck transfer
// - far master requests before using bus
// - arbiter raises separate data bus grant
module dev_end
  import sysbus_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sysbus_if.dev bus,
  input wire logic [`SB_TMO_W-1:0] tmo_limit,
  input wire logic mst_req,
  input wire logic mst_burst,
  input wire logic [`SB_DATA_W-1:0] mst_wdata,
  output logic mst_busy,
  output logic mst_done,
  output logic mst_err,
  output logic rx_valid,
  output logic [`SB_DATA_W-1:0] rx_data,
  output logic rx_par_err,
  output logic tmo_err
);
  dev_state_t state_r, state_nxt;
  logic [`SB_DATA_W-1:0] data_r, data_nxt, rx_data_r, rx_data_nxt;
  logic [`SB_LANES-1:0] par_r, par_nxt, par_exp;
  logic [`SB_BEAT_W-1:0] beat_r, beat_nxt;
  logic [`SB_TMO_W-1:0] tmr_r, tmr_nxt;
  logic oe_n_r, oe_n_nxt, valid_r, valid_nxt, burst_r, burst_nxt;
  logic ta_r, ta_nxt, tea_r, tea_nxt, gnt_r, gnt_nxt, dgnt_r, dgnt_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, err_r, err_nxt, tmo_r, tmo_nxt;
  logic rx_valid_r, rx_valid_nxt, rx_perr_r, rx_perr_nxt;

  genvar i;
  generate
    for (i = 0; i < `SB_LANES; i++)
    begin : g_par
      assign par_nxt[i] = ~^data_nxt[i*`SB_LANE_W +: `SB_LANE_W];
      assign par_exp[i] = ~^bus.data[i*`SB_LANE_W +: `SB_LANE_W];
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;
    data_nxt = data_r;
    beat_nxt = beat_r;
    tmr_nxt = tmr_r;
    oe_n_nxt = oe_n_r;
    valid_nxt = valid_r;
    burst_nxt = burst_r;
    gnt_nxt = gnt_r;
    dgnt_nxt = dgnt_r;
    busy_nxt = busy_r;
    ta_nxt = 1'b0;
    tea_nxt = 1'b0;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    tmo_nxt = 1'b0;
    rx_valid_nxt = 1'b0;
    rx_data_nxt = rx_data_r;
    rx_perr_nxt = 1'b0;
    unique case (state_r)
      D_IDLE:
      begin
        // a waiting far master is served before a new local transfer
        if (bus.far_master_request_b)
        begin
          state_nxt = D_GNT;
          gnt_nxt = 1'b1;
          dgnt_nxt = 1'b1;
          tmr_nxt = `SB_TMR_ZERO;
        end
        else if (mst_req)
        begin
          state_nxt = D_MST;
          data_nxt = mst_wdata;
          burst_nxt = mst_burst;
          oe_n_nxt = 1'b0;
          valid_nxt = 1'b1;
          busy_nxt = 1'b1;
          beat_nxt = `SB_FIRST_BEAT;
          tmr_nxt = `SB_TMR_ZERO;
        end
      end
      D_MST:
      begin
        if (bus.transfer_error_ack)
        begin
          err_nxt = 1'b1;
          state_nxt = D_IDLE;
          oe_n_nxt = 1'b1;
          valid_nxt = 1'b0;
          busy_nxt = 1'b0;
        end
        else if (bus.transfer_ack)
        begin
          tmr_nxt = `SB_TMR_ZERO;
          if (!burst_r || beat_r == `SB_LAST_BEAT)
          begin
            done_nxt = 1'b1;
            state_nxt = D_IDLE;
            oe_n_nxt = 1'b1;
            valid_nxt = 1'b0;
            busy_nxt = 1'b0;
          end
          else
          begin
            beat_nxt = beat_r + 1'b1;
            data_nxt = data_r + `SB_DATA_ONE;
          end
        end
        else if (tmr_r >= tmo_limit)
        begin
          tea_nxt = 1'b1;
          tmo_nxt = 1'b1;
          err_nxt = 1'b1;
          state_nxt = D_IDLE;
          oe_n_nxt = 1'b1;
          valid_nxt = 1'b0;
          busy_nxt = 1'b0;
        end
        else
        begin
          tmr_nxt = tmr_r + `SB_TMR_ONE;
        end
      end
      D_GNT:
      begin
        // registered ack lags one cycle, so ta_r blocks a second ack of the same beat
        if (bus.valid && !ta_r && !bus.transfer_error_ack)
        begin
          ta_nxt = 1'b1;
          rx_valid_nxt = 1'b1;
          rx_data_nxt = bus.data;
          rx_perr_nxt = (bus.parity != par_exp);
        end
        if (!bus.far_master_request_b)
        begin
          state_nxt = D_IDLE;
          gnt_nxt = 1'b0;
          dgnt_nxt = 1'b0;
          ta_nxt = 1'b0;
          rx_valid_nxt = 1'b0;
        end
        else if (bus.transfer_ack || ta_nxt)
        begin
          tmr_nxt = `SB_TMR_ZERO;
        end
        else if (tmr_r >= tmo_limit)
        begin
          // a far master that stalls the bus is cut off and told so
          tea_nxt = 1'b1;
          tmo_nxt = 1'b1;
          state_nxt = D_IDLE;
          gnt_nxt = 1'b0;
          dgnt_nxt = 1'b0;
        end
        else
        begin
          tmr_nxt = tmr_r + `SB_TMR_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= D_IDLE;
      data_r <= '0;
      par_r <= '1;
      beat_r <= `SB_FIRST_BEAT;
      tmr_r <= `SB_TMR_ZERO;
      oe_n_r <= 1'b1;
      valid_r <= 1'b0;
      burst_r <= 1'b0;
      gnt_r <= 1'b0;
      dgnt_r <= 1'b0;
      busy_r <= 1'b0;
      ta_r <= 1'b0;
      tea_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      tmo_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r <= '0;
      rx_perr_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      data_r <= data_nxt;
      par_r <= par_nxt;
      beat_r <= beat_nxt;
      tmr_r <= tmr_nxt;
      oe_n_r <= oe_n_nxt;
      valid_r <= valid_nxt;
      burst_r <= burst_nxt;
      gnt_r <= gnt_nxt;
      dgnt_r <= dgnt_nxt;
      busy_r <= busy_nxt;
      ta_r <= ta_nxt;
      tea_r <= tea_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      tmo_r <= tmo_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_data_r <= rx_data_nxt;
      rx_perr_r <= rx_perr_nxt;
    end
  end

  assign bus.dev_data_o = data_r;
  assign bus.dev_par_o = par_r;
  assign bus.dev_valid_o = valid_r;
  assign bus.dev_burst_o = burst_r;
  assign bus.dev_drv_oe_n = oe_n_r;
  assign bus.dev_ta_o = ta_r;
  assign bus.dev_ta_oe_n = !ta_r;
  assign bus.dev_tea_o = tea_r;
  assign bus.dev_tea_oe_n = !tea_r;
  assign bus.far_master_grant_c = gnt_r;
  assign bus.far_master_data_grant_b = dgnt_r;
  assign mst_busy = busy_r;
  assign mst_done = done_r;
  assign mst_err = err_r;
  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;
  assign rx_par_err = rx_perr_r;
  assign tmo_err = tmo_r;
endmodule : dev_end

// file: verif/sysbus_chk.sv
`timescale 1ns/1ns
`include "sysbus_cfg.svh"
module sysbus_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SB_DATA_W-1:0] data,
  input wire logic [`SB_LANES-1:0] parity,
  input wire logic valid,
  input wire logic burst,
  input wire logic transfer_ack,
  input wire logic transfer_error_ack,
  input wire logic far_master_request_b,
  input wire logic far_master_grant_c,
  input wire logic far_master_data_grant_b,
  input wire logic aux_valid,
  input wire logic aux_error_ack
);
  logic [`SB_LANES-1:0] exp_par;
  logic [3:0] acks_r;
  logic [3:0] acks_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_comb
  begin
    for (int i = 0; i < `SB_LANES; i++)
    begin
      exp_par[i] = ~^data[i*`SB_LANE_W +: `SB_LANE_W];
    end
  end
  // four bits so a sixteenth ack cannot wrap back to a legal count
  always_comb
  begin
    acks_nxt = acks_r;
    if (!valid)
      acks_nxt = 4'h0;
    else if (transfer_ack)
      acks_nxt = acks_r + 4'h1;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      acks_r <= 4'h0;
    else
      acks_r <= acks_nxt;
  end
  chk_parity_odd: assert property (valid |-> parity == exp_par)
    else $error("parity lanes not odd over their bytes");
  chk_grants_pair: assert property (far_master_grant_c == far_master_data_grant_b)
    else $error("bus grant and data grant differ");
  chk_grant_answer: assert property ($rose(far_master_request_b) |-> ##[1:40] far_master_grant_c)
    else $error("far request not granted in time");
  chk_grant_cause: assert property ($rose(far_master_grant_c) |-> $past(far_master_request_b))
    else $error("grant raised without request");
  chk_ack_err_excl: assert property (!(transfer_ack && transfer_error_ack))
    else $error("ack and error ack together");
  chk_ack_on_beat: assert property (transfer_ack |-> valid)
    else $error("ack without a data beat");
  chk_beat_answered: assert property ($rose(valid) |-> ##[1:10] (transfer_ack || transfer_error_ack))
    else $error("beat neither acked nor failed");
  chk_single_ends: assert property (transfer_ack && !burst |=> !valid)
    else $error("single beat not ended by its ack");
  chk_burst_eight: assert property ($fell(valid) && $past(burst) && !$past(transfer_error_ack)
    |-> $past(acks_r) == 4'h7)
    else $error("burst ended after wrong ack count");
  chk_error_ends: assert property (transfer_error_ack |=> !valid)
    else $error("tenure continued after error ack");
  // the unanswered bus is the only place the monitor ever fires
  chk_aux_err_ends: assert property (aux_error_ack |=> !aux_valid)
    else $error("unanswered tenure continued after error ack");
  chk_aux_answered: assert property ($rose(aux_valid) |-> ##[1:10] aux_error_ack)
    else $error("unanswered tenure not failed by monitor");
endmodule : sysbus_chk

// file: verif/system_bus_data_tenure_tb.sv
`timescale 1ns/1ns
`include "sysbus_cfg.svh"
module system_bus_data_tenure_tb;
  logic clk;
  logic rst;
  logic m_req, m_burst, o_req, o_burst, b_req;
  logic [`SB_DATA_W-1:0] m_wdata, o_wdata, d_rx, f_rx;
  logic m_done, m_err, d_rxv, d_pe, f_done, f_err, f_rxv, f_pe, b_err, b_tmo;
  logic m_busy, d_tmo;
  logic [7:0] tmo_lim;
  logic gnt_seen, tea_seen, tmo_seen;
  int cmp_count, bad_count, d_cnt, f_cnt, bad_ev;
  sysbus_if bus (.clk(clk), .rst(rst));
  sysbus_if bus2 (.clk(clk), .rst(rst));
  dev_end i_dev_end (.clk(clk), .rst(rst), .bus(bus.dev), .tmo_limit(tmo_lim), .mst_req(m_req),
    .mst_burst(m_burst), .mst_wdata(m_wdata), .mst_busy(m_busy), .mst_done(m_done),
    .mst_err(m_err), .rx_valid(d_rxv), .rx_data(d_rx), .rx_par_err(d_pe), .tmo_err(d_tmo));
  far_end i_far_end (.clk(clk), .rst(rst), .bus(bus.far), .own_req(o_req), .own_burst(o_burst),
    .own_wdata(o_wdata), .own_done(f_done), .own_err(f_err), .rx_valid(f_rxv), .rx_data(f_rx),
    .rx_par_err(f_pe));
  // second bus: a target that never answers, so only the monitor can end the tenure
  dev_end i_dev_end_b (.clk(clk), .rst(rst), .bus(bus2.dev), .tmo_limit(tmo_lim), .mst_req(b_req),
    .mst_burst(1'b0), .mst_wdata(m_wdata), .mst_busy(), .mst_done(), .mst_err(b_err),
    .rx_valid(), .rx_data(), .rx_par_err(), .tmo_err(b_tmo));
  sysbus_chk i_sysbus_chk (.clk(clk), .rst(rst), .data(bus.data), .parity(bus.parity),
    .valid(bus.valid), .burst(bus.burst), .transfer_ack(bus.transfer_ack),
    .transfer_error_ack(bus.transfer_error_ack), .far_master_request_b(bus.far_master_request_b),
    .far_master_grant_c(bus.far_master_grant_c),
    .far_master_data_grant_b(bus.far_master_data_grant_b), .aux_valid(bus2.valid),
    .aux_error_ack(bus2.transfer_error_ack));
  initial
  begin
    bus2.far_drv_oe_n = 1'b1;
    bus2.far_ta_oe_n = 1'b1;
    bus2.far_tea_oe_n = 1'b1;
    bus2.far_master_request_b = 1'b0;
    bus2.far_data_o = '0;
    bus2.far_par_o = '0;
    bus2.far_valid_o = 1'b0;
    bus2.far_burst_o = 1'b0;
    bus2.far_ta_o = 1'b0;
    bus2.far_tea_o = 1'b0;
  end
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (d_rxv === 1'b1)
      d_cnt++;
    if (f_rxv === 1'b1)
      f_cnt++;
    if (d_pe !== 1'b0 || f_pe !== 1'b0 || m_err !== 1'b0 || f_err !== 1'b0 || d_tmo !== 1'b0)
      bad_ev++;
    if (bus.far_master_grant_c === 1'b1)
      gnt_seen = 1'b1;
    if (bus2.transfer_error_ack === 1'b1)
      tea_seen = 1'b1;
    if (b_tmo === 1'b1)
      tmo_seen = 1'b1;
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic xfer(input bit far, input logic burst, input logic [63:0] base);
    int n;
    d_cnt = 0;
    f_cnt = 0;
    gnt_seen = 1'b0;
    if (far)
    begin
      o_burst = burst;
      o_wdata = base;
      o_req = 1'b1;
    end
    else
    begin
      m_burst = burst;
      m_wdata = base;
      m_req = 1'b1;
    end
    @(negedge clk);
    m_req = 1'b0;
    o_req = 1'b0;
    check("busy after take", {63'h0, !far}, {63'h0, m_busy});
    for (n = 0; n < 60 && m_done !== 1'b1 && f_done !== 1'b1; n++)
      @(negedge clk);
    @(negedge clk);
    check("finished", 64'h1, {63'h0, n < 60});
    check("busy after end", 64'h0, {63'h0, m_busy});
    check("beats", burst ? 8 : 1, far ? d_cnt : f_cnt);
    check("last data", base + (burst ? 7 : 0), far ? d_rx : f_rx);
    check("grant seen", {63'h0, far}, {63'h0, gnt_seen});
    $display("test xfer far=%0d burst=%0d done", far, burst);
  endtask : xfer
  task automatic tmo_test(input logic [7:0] lim);
    int n;
    tmo_lim = lim;
    tea_seen = 1'b0;
    tmo_seen = 1'b0;
    b_req = 1'b1;
    @(negedge clk);
    b_req = 1'b0;
    for (n = 0; n < 40 && b_err !== 1'b1; n++)
      @(negedge clk);
    check("master error", 64'h1, {63'h0, b_err});
    check("timeout span", {56'h0, lim} + 64'h1, n);
    // sticky flags are set by the sampler at this same edge, so read them one cycle on
    @(negedge clk);
    check("monitor timeout", 64'h1, {63'h0, tmo_seen});
    check("error ack driven", 64'h1, {63'h0, tea_seen});
    check("beat released", 64'h0, {63'h0, bus2.valid});
    $display("test tmo_test limit=%0d done", lim);
  endtask : tmo_test
  initial
  begin
    rst = 1'b1;
    m_req = 1'b0;
    o_req = 1'b0;
    b_req = 1'b0;
    m_burst = 1'b0;
    o_burst = 1'b0;
    m_wdata = '0;
    o_wdata = '0;
    tmo_lim = 8'h04;
    tea_seen = 1'b0;
    tmo_seen = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    xfer(1'b0, 1'b0, 64'h0123456789ABCDEF);
    xfer(1'b0, 1'b1, 64'hFFFFFFFFFFFFFFF8);
    xfer(1'b1, 1'b0, 64'h8000000000000001);
    xfer(1'b1, 1'b1, 64'h00FF00FF00FF00F0);
    tmo_test(8'h04);
    tmo_test(8'h02);
    check("stray error pulses", 64'h0, bad_ev);
    end_sim;
  end
  // all tests need well under a thousand cycles
  initial
  begin
    #80000;
    bad_count++;
    end_sim;
  end
endmodule : system_bus_data_tenure_tb
